// file: rtl/aes_event_regs.sv
/*
  Event flag, face and result registers of the accelerometer.
  Assumes a bus slave on link_clk that hands over one register access
  at a time, and a measurement engine on clk giving sample pulses.
*/
`include "aes_params.svh"
module aes_event_regs (
  input  logic                clk,
  input  logic                rstn,
  input  logic                link_clk,
  input  logic                link_req_valid,
  input  aes_pkg::aes_req_t   link_req,
  input  logic                link_xfer_active,
  output logic                link_busy,
  output logic [7:0]          link_rdata,
  output logic                link_done,
  input  logic                sample_valid,
  input  aes_pkg::aes_sample_t sample,
  input  logic [3:0]          shake_evt,
  input  logic                calib_done,
  input  logic [7:0]          int_mask0,
  input  logic                int_mask1_sample_ready_flag,
  input  logic [1:0]          face_settle_count,
  output logic [3:0]          shake_hold,
  output logic                soft_reset,
  output logic                int_out,
  output logic                int_oe
);
  import aes_pkg::*;

  function automatic logic [11:0] mag(input logic [11:0] v);
    mag = v[11] ? 12'(~v + 12'h001) : v;
  endfunction

  // ----------------------------------------
  // link side, exempt from soft reset
  // ----------------------------------------
  aes_req_t   lreq_q;
  logic       ltog_q;
  logic       lbusy_q;
  logic       ldone_q;
  logic [7:0] lrd_q;
  logic       ack_m_q;
  logic       ack_s_q;
  logic       ack_p_q;
  logic       cack_q;
  logic [7:0] crd_q;

  always_ff @(posedge link_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ack_m_q <= 1'b0;
      ack_s_q <= 1'b0;
      ack_p_q <= 1'b0;
    end
    else
    begin
      ack_m_q <= cack_q;
      ack_s_q <= ack_m_q;
      ack_p_q <= ack_s_q;
    end
  end

  always_ff @(posedge link_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lreq_q  <= '0;
      ltog_q  <= 1'b0;
      lbusy_q <= 1'b0;
      ldone_q <= 1'b0;
      lrd_q   <= `AES_RST_BYTE;
    end
    else
    begin
      ldone_q <= 1'b0;
      if (link_req_valid && !lbusy_q)
      begin
        lreq_q  <= link_req;
        ltog_q  <= ~ltog_q;
        lbusy_q <= 1'b1;
      end
      else if (lbusy_q && (ack_s_q ^ ack_p_q))
      begin
        lbusy_q <= 1'b0;
        ldone_q <= 1'b1;
        lrd_q   <= crd_q;
      end
    end
  end

  assign link_busy  = lbusy_q;
  assign link_done  = ldone_q;
  assign link_rdata = lrd_q;

  // ----------------------------------------
  // core side of the crossing
  // ----------------------------------------
  logic req_m_q;
  logic req_s_q;
  logic req_p_q;
  logic xfer_m_q;
  logic xfer_s_q;
  logic go;
  logic wr_go;
  logic [7:0] rd_c;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      req_m_q  <= 1'b0;
      req_s_q  <= 1'b0;
      req_p_q  <= 1'b0;
      xfer_m_q <= 1'b0;
      xfer_s_q <= 1'b0;
    end
    else
    begin
      req_m_q  <= ltog_q;
      req_s_q  <= req_m_q;
      req_p_q  <= req_s_q;
      xfer_m_q <= link_xfer_active;
      xfer_s_q <= xfer_m_q;
    end
  end

  // request fields stay still in lreq_q until the ack returns
  assign go    = req_s_q ^ req_p_q;
  assign wr_go = go && lreq_q.write;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cack_q <= 1'b0;
      crd_q  <= `AES_RST_BYTE;
    end
    else if (go)
    begin
      cack_q <= ~cack_q;
      if (!lreq_q.write)
        crd_q <= rd_c;
    end
  end

  // ----------------------------------------
  // soft reset
  // ----------------------------------------
  logic srst_q;
  logic [7:0] clr0;
  logic [7:0] clr1;

  assign clr0 = (wr_go && lreq_q.addr == `AES_OFS_FLAGS0) ?
                lreq_q.wdata : 8'h00;
  assign clr1 = (wr_go && lreq_q.addr == `AES_OFS_FLAGS1) ?
                lreq_q.wdata : 8'h00;

  // held while the bus transfer is open, so the slave can still ack
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      srst_q <= 1'b0;
    else if (clr1[`AES_B_SRST])
      srst_q <= 1'b1;
    else if (srst_q)
      srst_q <= xfer_s_q;
  end

  assign soft_reset = srst_q;

  // ----------------------------------------
  // measurement capture and raw face
  // ----------------------------------------
  logic [11:0] x_q;
  logic [11:0] y_q;
  logic [11:0] ax;
  logic [11:0] ay;
  logic        tilt_c;
  aes_face_t   xy_c;
  aes_face_t   xyraw_q;
  aes_face_t   zraw_q;
  logic        samp_d_q;
  logic        calib_q;

  assign ax     = mag(sample.x);
  assign ay     = mag(sample.y);
  assign tilt_c = (ax >= ay ? ax : ay) <= `AES_TILT_LSB;
  assign xy_c   = (ax >= ay) ? {sample.x[11], 1'b0}
                             : {sample.y[11], 1'b1};

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      x_q      <= 12'h000;
      y_q      <= 12'h000;
      xyraw_q  <= `AES_RST_FACE;
      zraw_q   <= `AES_RST_FACE;
      samp_d_q <= 1'b0;
    end
    else if (srst_q)
    begin
      x_q      <= 12'h000;
      y_q      <= 12'h000;
      xyraw_q  <= `AES_RST_FACE;
      zraw_q   <= `AES_RST_FACE;
      samp_d_q <= 1'b0;
    end
    else
    begin
      samp_d_q <= sample_valid;
      if (sample_valid)
      begin
        x_q    <= sample.x;
        y_q    <= sample.y;
        zraw_q <= {tilt_c, sample.z[11]};
        if (!tilt_c)
          xyraw_q <= xy_c;
      end
    end
  end

  // calibration flag survives soft reset: no load repeats here
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      calib_q <= 1'b0;
    else if (calib_done)
      calib_q <= 1'b1;
  end

  // ----------------------------------------
  // filtered faces
  // ----------------------------------------
  aes_face_t xyf;
  aes_face_t zf;
  logic      xy_chg;
  logic      z_chg;

  aes_face_filter u_xy_filt (
    .clk       (clk),
    .rstn      (rstn),
    .srst      (srst_q),
    .sample    (samp_d_q && !zraw_q[1]),
    .raw       (xyraw_q),
    .sel       (face_settle_count),
    .code_q    (xyf),
    .changed_q (xy_chg)
  );

  aes_face_filter u_z_filt (
    .clk       (clk),
    .rstn      (rstn),
    .srst      (srst_q),
    .sample    (samp_d_q),
    .raw       (zraw_q),
    .sel       (face_settle_count),
    .code_q    (zf),
    .changed_q (z_chg)
  );

  // ----------------------------------------
  // event flags
  // ----------------------------------------
  logic [3:0] shake_q;
  logic       xychg_q;
  logic       zchg_q;
  logic       sample_ready_flag_q;

  // set terms come after the clear so a colliding event survives
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      shake_q <= 4'h0;
      xychg_q <= 1'b0;
      zchg_q  <= 1'b0;
      sample_ready_flag_q  <= 1'b0;
    end
    else if (srst_q)
    begin
      shake_q <= 4'h0;
      xychg_q <= 1'b0;
      zchg_q  <= 1'b0;
      sample_ready_flag_q  <= 1'b0;
    end
    else
    begin
      shake_q <= (shake_q & ~clr0[3:0]) | shake_evt;
      xychg_q <= (xychg_q & ~clr0[6]) | xy_chg;
      zchg_q  <= (zchg_q & ~clr0[7]) | z_chg;
      sample_ready_flag_q  <= (sample_ready_flag_q & ~clr1[`AES_B_SAMPLE_READY_FLAG])
                 | sample_valid;
    end
  end

  // detector stops per axis while its flag stands
  assign shake_hold = shake_q;

  // ----------------------------------------
  // interrupt pin, open drain, active low
  // ----------------------------------------
  logic [7:0] flags0;
  logic [7:0] flags1;
  logic       int_oe_q;
  logic       int_out_q;

  assign flags0 = {zchg_q, xychg_q, 2'b00, shake_q};
  assign flags1 = {zf, xyf, 3'b000, sample_ready_flag_q};

  // mask only gates the pin, flags set regardless
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      int_oe_q  <= 1'b0;
      int_out_q <= 1'b0;
    end
    else
    begin
      int_oe_q  <= |(flags0 & int_mask0)
                   | (sample_ready_flag_q & int_mask1_sample_ready_flag);
      int_out_q <= 1'b0;
    end
  end

  assign int_oe  = int_oe_q;
  assign int_out = int_out_q;

  // ----------------------------------------
  // read decode
  // ----------------------------------------
  always_comb
  begin
    rd_c = 8'h00;
    unique case (lreq_q.addr)
      `AES_OFS_FLAGS0: rd_c = flags0;
      `AES_OFS_FLAGS1: rd_c = flags1;
      `AES_OFS_FACE:   rd_c = {3'b000, calib_q, zraw_q, xyraw_q};
      `AES_OFS_XHI:    rd_c = x_q[11:4];
      `AES_OFS_XLO:    rd_c = {x_q[3:0], 4'h0};
      `AES_OFS_YHI:    rd_c = y_q[11:4];
      `AES_OFS_YLO:    rd_c = {y_q[3:0], 4'h0};
      default:         rd_c = 8'h00;
    endcase
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_sample;
    sample_valid && !srst_q;
  endsequence

  sequence s_sample_ready_flag_clear;
    wr_go && lreq_q.addr == `AES_OFS_FLAGS1
      && lreq_q.wdata[`AES_B_SAMPLE_READY_FLAG];
  endsequence

  chk_sample_ready_flag_set_wins: assert property (
    s_sample |=> sample_ready_flag_q)
    else $error("data ready not set after sample");

  chk_sample_ready_flag_clear: assert property (
    s_sample_ready_flag_clear ##0 (!sample_valid && !srst_q) |=> !sample_ready_flag_q)
    else $error("data ready not cleared by write");

  chk_shake_set: assert property (
    shake_evt[0] && !srst_q |=> shake_q[0] && shake_hold[0])
    else $error("shake flag missing");

  chk_int_pin: assert property (
    (|(flags0 & int_mask0)) |=> int_oe && !int_out)
    else $error("interrupt pin not driven low");

  chk_calib_sticky: assert property (
    calib_q |=> calib_q)
    else $error("calibration flag dropped");

  chk_xy_frozen: assert property (
    s_sample ##0 tilt_c |=> $stable(xyraw_q))
    else $error("xy code moved while tilted");

  chk_srst_hold: assert property (
    srst_q && xfer_s_q |=> srst_q)
    else $error("soft reset released during transfer");

  chk_x_result: assert property (
    s_sample |=> x_q == $past(sample.x))
    else $error("x result not captured");

  chk_srst_clears: assert property (
    srst_q ##1 srst_q |-> !sample_ready_flag_q && shake_q == 4'h0)
    else $error("flags survive soft reset");
endmodule // aes_event_regs

// file: rtl/aes_params.svh
/*
  Offsets, bit positions and counts of the accelerometer event and
  status register bank. Assumes 8-bit registers, 4-bit addresses.
*/
// How it works
// - seven 8-bit registers sit at addresses 0x00 to 0x06, the rest up to 0x0F read zero
// - 0x00 and 0x01 read event flags, writes go to clear registers
// - an event sets its flag bit to one
// - master writes one to a clear bit, the device clears that flag
// - shake flags D0..D3 mean +X, -X, +Y, -Y; clear bits match
// - a set shake flag blocks further shake detection on that axis
// - D6 flags an XY face change, D7 flags a Z face change
// - XY code: 00 +X, 01 +Y, 10 -X, 11 -Y
// - XY code updates only when the larger of X, Y exceeds 0.375g
// - Z field holds tilt above, sign of Z below (1 negative)
// - tilt is set when XY is too small, XY code then frozen
// - a new face is taken only after consecutive valid readings
// - new measurement sets the data ready flag D0, cleared by D0
// - writing one to D4 at 0x01 resets flags, faces, filters and results to power-up; calibration flag kept
// - soft reset lasts while the transfer lasts; link side exempt
// - 0x02 shows unfiltered XY code in 1:0 and Z code in 3:2
// - 0x02 D4 becomes one after calibration load, never cleared
// - X result 12-bit: 11:4 at 0x03, 3:0 in D7:D4 of 0x04
// - 0x05 holds Y bits 11:4 laid out like the X upper register
// - interrupt pin is low while any enabled flag is set
// - flags are set whatever the mask says
// - settle count codes 00..11 select 16, 32, 64, 128 readings
`ifndef AES_PARAMS_SVH
`define AES_PARAMS_SVH
`define AES_OFS_FLAGS0 4'h0
`define AES_OFS_FLAGS1 4'h1
`define AES_OFS_FACE   4'h2
`define AES_OFS_XHI    4'h3
`define AES_OFS_XLO    4'h4
`define AES_OFS_YHI    4'h5
`define AES_OFS_YLO    4'h6
`define AES_B_SRST     4
`define AES_B_SAMPLE_READY_FLAG     0
`define AES_FACE_BASE  8'h10
`define AES_TILT_LSB   12'h180
`define AES_RST_FACE   2'h0
`define AES_RST_BYTE   8'h00
`endif

// file: rtl/aes_pkg.sv
/*
  Types shared by the event register bank and its face filter.
  Assumes nothing beyond the parameter header.
*/
package aes_pkg;
  typedef logic [1:0] aes_face_t;
  typedef struct packed {
    logic [11:0] x;
    logic [11:0] y;
    logic [11:0] z;
  } aes_sample_t;
  typedef struct packed {
    logic       write;
    logic [3:0] addr;
    logic [7:0] wdata;
  } aes_req_t;
endpackage

// file: rtl/aes_face_filter.sv
/*
  Consecutive-reading filter for one two-bit face code.
  Assumes one sample pulse per reading on the core clock.
*/
`include "aes_params.svh"
module aes_face_filter (
  input  logic             clk,
  input  logic             rstn,
  input  logic             srst,
  input  logic             sample,
  input  aes_pkg::aes_face_t raw,
  input  logic [1:0]       sel,
  output aes_pkg::aes_face_t code_q,
  output logic             changed_q
);
  import aes_pkg::*;
  aes_face_t  cand_q;
  logic [7:0] cnt_q;
  logic [7:0] lim;
  assign lim = `AES_FACE_BASE << sel;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      code_q    <= `AES_RST_FACE;
      cand_q    <= `AES_RST_FACE;
      cnt_q     <= 8'h00;
      changed_q <= 1'b0;
    end
    else if (srst)
    begin
      code_q    <= `AES_RST_FACE;
      cand_q    <= `AES_RST_FACE;
      cnt_q     <= 8'h00;
      changed_q <= 1'b0;
    end
    else
    begin
      changed_q <= 1'b0;
      if (sample)
      begin
        if (raw == code_q)
          cnt_q <= 8'h00;
        else if (raw != cand_q || cnt_q == 8'h00)
        begin
          cand_q <= raw;
          cnt_q  <= 8'h01;
        end
        else if (cnt_q + 8'h01 >= lim)
        begin
          code_q    <= raw;
          changed_q <= 1'b1;
          cnt_q     <= 8'h00;
        end
        else
          cnt_q <= cnt_q + 8'h01;
      end
    end
  end
endmodule // aes_face_filter

// file: verif/aes_link_model.sv
/*
  Link-side master model: one register access at a time.
  Assumes the block takes a request on link_clk while not busy.
*/
module aes_link_model (
  input  logic              link_clk,
  input  logic [7:0]        link_rdata,
  input  logic              link_done,
  output logic              link_req_valid,
  output aes_pkg::aes_req_t link_req,
  output logic              link_xfer_active
);
  timeunit 1ns;
  timeprecision 100ps;
  import aes_pkg::*;

  initial
  begin
    link_req_valid   = 1'b0;
    link_req         = '0;
    link_xfer_active = 1'b0;
  end

  // ---------------------------------------------------------------
  // one byte per request, next one only after done
  // ---------------------------------------------------------------
  task automatic access(input logic wr, input logic [3:0] a,
    input logic [7:0] wd, input logic keep,
    output logic [7:0] rd, output logic ok);
    ok = 1'b0;
    @(negedge link_clk);
    link_xfer_active = 1'b1;
    link_req_valid   = 1'b1;
    link_req         = '{write: wr, addr: a, wdata: wd};
    @(negedge link_clk);
    link_req_valid = 1'b0;
    // released fields must not keep looking like the last request
    link_req = ~link_req;
    for (int i = 0; i < 100 && !ok; i++)
    begin
      @(negedge link_clk);
      ok = (link_done === 1'b1);
    end
    rd = link_rdata;
    // keep holds the transfer open, as a soft reset write may want
    if (!keep)
      link_xfer_active = 1'b0;
  endtask

  // closes a transfer left open by a keep access
  task automatic end_xfer();
    @(negedge link_clk);
    link_xfer_active = 1'b0;
  endtask
endmodule // aes_link_model

// file: verif/tb.sv
/*
  Self-checking bench of the event and status register bank.
  Assumes the link master model and the design package.
*/
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import aes_pkg::*;

  logic        clk;
  logic        rstn;
  logic        link_clk;
  logic        link_req_valid;
  aes_req_t    link_req;
  logic        link_xfer_active;
  logic        link_busy;
  logic [7:0]  link_rdata;
  logic        link_done;
  logic        sample_valid;
  aes_sample_t sample;
  logic [3:0]  shake_evt;
  logic        calib_done;
  logic [7:0]  int_mask0;
  logic        int_mask1_sample_ready_flag;
  logic [1:0]  face_settle_count;
  logic [3:0]  shake_hold;
  logic        soft_reset;
  logic        int_out;
  logic        int_oe;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  aes_event_regs dut_u (.clk(clk), .rstn(rstn), .link_clk(link_clk),
    .link_req_valid(link_req_valid), .link_req(link_req),
    .link_xfer_active(link_xfer_active), .link_busy(link_busy),
    .link_rdata(link_rdata), .link_done(link_done),
    .sample_valid(sample_valid), .sample(sample),
    .shake_evt(shake_evt), .calib_done(calib_done),
    .int_mask0(int_mask0), .int_mask1_sample_ready_flag(int_mask1_sample_ready_flag),
    .face_settle_count(face_settle_count), .shake_hold(shake_hold),
    .soft_reset(soft_reset), .int_out(int_out), .int_oe(int_oe));

  aes_link_model link_u (.link_clk(link_clk), .link_rdata(link_rdata),
    .link_done(link_done), .link_req_valid(link_req_valid),
    .link_req(link_req), .link_xfer_active(link_xfer_active));

  // ---------------------------------------------------------------
  // clocks and hang guard
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    link_clk = 1'b0;
    #1.7;
    forever #3 link_clk = ~link_clk;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      bad_count++;
      $display("timeout at cycle %0d", cyc);
      results();
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] e,
    input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    link_u.access(1'b0, a, 8'h00, 1'b0, d, ok);
    chk("read done", 8'h01, {7'h00, ok});
    chk($sformatf("reg %h", a), e, d);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v,
    input logic keep);
    logic [7:0] d;
    logic       ok;
    link_u.access(1'b1, a, v, keep, d, ok);
    chk("write done", 8'h01, {7'h00, ok});
  endtask

  task automatic smp(input logic [11:0] x, y, z, input int n);
    repeat (n)
    begin
      @(negedge clk);
      sample_valid = 1'b1;
      sample = '{x: x, y: y, z: z};
      @(negedge clk);
      sample_valid = 1'b0;
      repeat (4) @(negedge clk);
    end
  endtask

  // waits up to eight cycles for the level, then judges it
  task automatic wait_is(input bit sr, input logic e);
    logic v;
    for (int i = 0; i < 8; i++)
    begin
      v = sr ? soft_reset : int_oe;
      if (v !== e)
        @(negedge clk);
    end
    v = sr ? soft_reset : int_oe;
    chk(sr ? "soft_reset" : "int_oe", {7'h00, e}, {7'h00, v});
  endtask

  task automatic pulse_in(input bit cal, input logic [3:0] s);
    @(negedge clk);
    calib_done = cal;
    shake_evt = s;
    @(negedge clk);
    calib_done = 1'b0;
    shake_evt = 4'h0;
    repeat (3) @(negedge clk);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    for (int a = 0; a < 16; a++)
      rd(a[3:0], 8'h00);
    chk("shake_hold", 8'h00, {4'h0, shake_hold});
    chk("link_busy", 8'h00, {7'h00, link_busy});
    chk("int_out", 8'h00, {7'h00, int_out});
    $display("test reset done");
  endtask

  task automatic t_sample();
    int_mask1_sample_ready_flag = 1'b1;
    smp(12'h010, 12'h400, 12'h020, 1);
    rd(4'h2, 8'h01);
    smp(12'hF9C, 12'hA05, 12'h020, 1);
    rd(4'h2, 8'h03);
    rd(4'h3, 8'hF9);
    rd(4'h4, 8'hC0);
    rd(4'h5, 8'hA0);
    rd(4'h1, 8'h01);
    wait_is(1'b0, 1'b1);
    wr(4'h1, 8'h01, 1'b0);
    rd(4'h1, 8'h00);
    wait_is(1'b0, 1'b0);
    $display("test sample done");
  endtask

  task automatic t_face();
    smp(12'h900, 12'h100, 12'h020, 15);
    rd(4'h0, 8'h00);
    smp(12'h900, 12'h100, 12'h020, 1);
    rd(4'h0, 8'h40);
    rd(4'h1, 8'h21);
    // exactly the threshold is still too small to decide
    smp(12'h180, 12'h000, 12'hC00, 16);
    pulse_in(1'b1, 4'h0);
    rd(4'h0, 8'hC0);
    rd(4'h1, 8'hE1);
    rd(4'h2, 8'h1E);
    $display("test face done");
  endtask

  // settle code 01 asks for 32 readings on both faces
  task automatic t_count();
    face_settle_count = 2'h1;
    wr(4'h0, 8'hC0, 1'b0);
    smp(12'h400, 12'h000, 12'h020, 31);
    rd(4'h0, 8'h00);
    smp(12'h400, 12'h000, 12'h020, 1);
    rd(4'h0, 8'hC0);
    rd(4'h1, 8'h01);
    face_settle_count = 2'h0;
    $display("test count done");
  endtask

  task automatic t_shake();
    int_mask1_sample_ready_flag = 1'b0;
    wr(4'h0, 8'hC0, 1'b0);
    rd(4'h0, 8'h00);
    pulse_in(1'b0, 4'h5);
    chk("shake_hold", 8'h05, {4'h0, shake_hold});
    wait_is(1'b0, 1'b0);
    int_mask0 = 8'h04;
    wait_is(1'b0, 1'b1);
    chk("int_out", 8'h00, {7'h00, int_out});
    wr(4'h0, 8'h01, 1'b0);
    rd(4'h0, 8'h04);
    chk("shake_hold", 8'h04, {4'h0, shake_hold});
    wr(4'h0, 8'hFF, 1'b0);
    rd(4'h0, 8'h00);
    $display("test shake done");
  endtask

  task automatic t_srst();
    int_mask1_sample_ready_flag = 1'b1;
    wait_is(1'b0, 1'b1);
    wr(4'h1, 8'h10, 1'b1);
    wait_is(1'b1, 1'b1);
    repeat (40) @(negedge clk);
    wait_is(1'b1, 1'b1);
    link_u.end_xfer();
    wait_is(1'b1, 1'b0);
    wait_is(1'b0, 1'b0);
    rd(4'h1, 8'h00);
    rd(4'h3, 8'h00);
    rd(4'h2, 8'h10);
    $display("test soft reset done");
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    rstn = 1'b0;
    sample_valid = 1'b0;
    sample = '0;
    shake_evt = 4'h0;
    calib_done = 1'b0;
    int_mask0 = 8'h00;
    int_mask1_sample_ready_flag = 1'b0;
    face_settle_count = 2'h0;
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    t_reset();
    t_sample();
    t_face();
    t_count();
    t_shake();
    t_srst();
    results();
  end
endmodule // tb
